// [rtl/temp_mon_pkg.sv]
// constants and types for the die temperature and battery monitor
// assumes a 100 MHz core clock and byte-wide registers at 16-bit byte addresses
package temp_mon_pkg;

   localparam int CLK_HZ               = 100_000_000;
   localparam int WRITE_PENDING_MS     = 6;
   localparam int WRITE_PENDING_CYCLES = WRITE_PENDING_MS * (CLK_HZ / 1000);
   localparam int TICK_S               = 1;
   localparam int TICK_CYCLES          = TICK_S * CLK_HZ;

   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [15:0] ADDR_VCO_TEST = 16'h2500;
   localparam logic [15:0] ADDR_LOAD     = 16'h2704;
   localparam logic [15:0] ADDR_TEMP_HI  = 16'h2881;
   localparam logic [15:0] ADDR_TEMP_LO  = 16'h2882;
   localparam logic [15:0] ADDR_BATT     = 16'h2885;
   localparam logic [15:0] ADDR_CONFIG   = 16'h28A0;
   localparam logic [15:0] ADDR_TRIGGER  = 16'h28B4;

   localparam int CFG_BSEL_BIT = 7;
   localparam int CFG_PWR_BIT  = 6;
   localparam int CFG_BAT_BIT  = 4;
   localparam int LOAD_EN_BIT  = 3;
   localparam int TRIGGER_BIT  = 6;

   localparam logic [2:0] INTERVAL_MANUAL     = 3'h0;
   localparam logic [2:0] INTERVAL_CONTINUOUS = 3'h7;
   localparam logic [3:0] INTERVAL_BASE_EXP   = 4'h3;
   localparam int         SEC_CNT_W           = 9;

   localparam logic [7:0]  CONFIG_RESET   = 8'h00;
   localparam logic [1:0]  VCO_TEST_RESET = 2'h0;
   localparam logic        LOAD_RESET     = 1'b0;
   localparam logic        TRIGGER_RESET  = 1'b0;
   localparam logic [10:0] TEMP_RESET     = 11'h000;
   localparam logic [7:0]  BATT_RESET     = 8'h00;

   typedef enum logic [1:0] {
      normal_power_mode   = 2'h0,
      brownout_power_mode = 2'h1,
      display_only_mode   = 2'h2,
      deep_sleep_mode     = 2'h3
   } power_mode_t;

endpackage

// [rtl/meas_if.sv]
// handshake between the measurement controller and the sensor sequencer
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface meas_if;
   logic        start;
   logic        batt_en;
   logic        busy;
   logic        done;
   logic [10:0] temp;
   logic [7:0]  batt;

   modport ctrl (output start, output batt_en, input busy, input done, input temp, input batt);
   modport seq  (input start, input batt_en, output busy, output done, output temp, output batt);
endinterface

// [rtl/measure_sequencer.sv]
// runs one sensor conversion: raises the run request, waits for the sensor's done
// assumes sensor data stand stable while the sensor holds done high
`timescale 1ns/1ps
module measure_sequencer (
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   meas_if.seq              m,
   input  wire logic        sensor_done_in,
   input  wire logic [10:0] sensor_temp_in,
   input  wire logic [7:0]  sensor_batt_in,
   output logic             sensor_run_out,
   output logic             sensor_batt_meas_out
);

   typedef enum logic [2:0] {
      st_idle  = 3'b001,
      st_run   = 3'b010,
      st_drain = 3'b100
   } seq_state_t;

   seq_state_t  state_r;
   seq_state_t  state_nxt;
   logic        done_s1_r;
   logic        done_s2_r;
   logic        batt_r;
   logic        done_r;
   logic [10:0] temp_r;
   logic [7:0]  batt_val_r;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         st_idle:  if (m.start) state_nxt = st_run;
         st_run:   if (done_s2_r) state_nxt = st_drain;
         st_drain: if (!done_s2_r) state_nxt = st_idle;
         default:  state_nxt = st_idle;
      endcase
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         done_s1_r <= 1'b0;
         done_s2_r <= 1'b0;
         state_r   <= st_idle;
      end else begin
         done_s1_r <= sensor_done_in;
         done_s2_r <= done_s1_r;
         state_r   <= state_nxt;
      end
   end

   // done pulses once per conversion, with both results captured in the same edge
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         batt_r     <= 1'b0;
         done_r     <= 1'b0;
         temp_r     <= temp_mon_pkg::TEMP_RESET;
         batt_val_r <= temp_mon_pkg::BATT_RESET;
      end else begin
         done_r <= (state_r == st_run) && done_s2_r;
         if ((state_r == st_idle) && m.start) begin
            batt_r <= m.batt_en;
         end
         if ((state_r == st_run) && done_s2_r) begin
            temp_r     <= sensor_temp_in;
            batt_val_r <= sensor_batt_in;
         end
      end
   end

   assign sensor_run_out       = state_r[1];
   assign sensor_batt_meas_out = batt_r;
   assign m.busy               = !state_r[0];
   assign m.done               = done_r;
   assign m.temp               = temp_r;
   assign m.batt               = batt_val_r;

endmodule

// [rtl/die_temp_battery_monitor.sv]
// register file and measurement scheduling for the die temperature and battery monitor
// assumes a plain byte register port on the core clock; power mode comes from core logic
`timescale 1ns/1ps

// Operation
// - normal and brownout modes measure on the trigger bit with interval zero, and automatically otherwise
// - sleep and display-only modes measure automatically at the interval rate
// - periodic automatic measurement works in every power mode
// - interval 0 manual, 1 to 6 period 2^(3+n) s, 7 continuous
// - result upper eight bits one byte, lower three bits top of next
// - eleven-bit result is two's complement, -1024 to +1023
// - config write pending flag reads one, further writes ignored, up to 6 ms
// - trigger acts only with interval zero and starts one measurement
// - trigger ignored in sleep and display-only modes
// - hardware clears trigger when its measurement completes
// - supply select: 1 digital rail, 0 clock battery; forced battery in low modes
// - battery select: 1 main backup battery, 0 clock battery, measure and load
// - battery check bit adds battery reading to every measurement
// - normal mode load enable connects load to selected battery
// - load never applied in brownout, display-only or sleep modes
module die_temp_battery_monitor #(
   parameter int WRITE_PENDING_CYCLES = temp_mon_pkg::WRITE_PENDING_CYCLES,
   parameter int TICK_CYCLES          = temp_mon_pkg::TICK_CYCLES
) (
   input  wire logic                      clk_in,
   input  wire logic                      reset_n_in,
   input  wire logic [15:0]               addr_in,
   input  wire logic [7:0]                wr_data_in,
   input  wire logic                      wr_in,
   input  wire logic                      rd_in,
   output logic      [7:0]                rd_data_out,
   input  wire temp_mon_pkg::power_mode_t power_mode_in,
   input  wire logic                      sensor_done_in,
   input  wire logic [10:0]               sensor_temp_in,
   input  wire logic [7:0]                sensor_batt_in,
   output logic                           sensor_run_out,
   output logic                           sensor_batt_meas_out,
   output logic                           sensor_supply_digital_out,
   output logic                           battery_main_sel_out,
   output logic                           battery_load_en_out,
   output logic      [1:0]                sensor_vco_test_out
);

   localparam int PEND_W = $clog2(WRITE_PENDING_CYCLES + 1);
   localparam int TICK_W = $clog2(TICK_CYCLES + 1);
   localparam int SEC_W  = temp_mon_pkg::SEC_CNT_W;

   meas_if m ();

   logic [1:0]        vco_test_r;
   logic              load_en_r;
   logic [2:0]        interval_r;
   logic              bat_check_r;
   logic              supply_sel_r;
   logic              batt_sel_r;
   logic [7:0]        cfg_stage_r;
   logic              pending_r;
   logic [PEND_W-1:0] pend_cnt_r;
   logic              trigger_r;
   logic              trigger_nxt;
   logic              manual_run_r;
   logic              start_r;
   logic              batt_taken_r;
   logic              periodic_req_r;
   logic [TICK_W-1:0] tick_cnt_r;
   logic [SEC_W-1:0]  sec_cnt_r;
   logic [10:0]       temp_r;
   logic [7:0]        batt_r;
   logic [7:0]        rd_data_r;
   logic              supply_r;
   logic              load_r;

   ////////////////////////////////////////////////////////////////////////////////
   // address decode and mode decode

   wire hit_vco  = (addr_in == temp_mon_pkg::ADDR_VCO_TEST);
   wire hit_load = (addr_in == temp_mon_pkg::ADDR_LOAD);
   wire hit_thi  = (addr_in == temp_mon_pkg::ADDR_TEMP_HI);
   wire hit_tlo  = (addr_in == temp_mon_pkg::ADDR_TEMP_LO);
   wire hit_batt = (addr_in == temp_mon_pkg::ADDR_BATT);
   wire hit_cfg  = (addr_in == temp_mon_pkg::ADDR_CONFIG);
   wire hit_trig = (addr_in == temp_mon_pkg::ADDR_TRIGGER);

   wire wr_vco   = wr_in && hit_vco;
   wire wr_load  = wr_in && hit_load;
   wire wr_trig  = wr_in && hit_trig;
   wire cfg_take = wr_in && hit_cfg && !pending_r;

   wire pend_last  = (pend_cnt_r == PEND_W'(WRITE_PENDING_CYCLES - 1));
   wire cfg_commit = pending_r && pend_last;

   wire low_power  = (power_mode_in == temp_mon_pkg::deep_sleep_mode) ||
                     (power_mode_in == temp_mon_pkg::display_only_mode);
   wire normal_pwr = (power_mode_in == temp_mon_pkg::normal_power_mode);

   ////////////////////////////////////////////////////////////////////////////////
   // software registers

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         vco_test_r <= temp_mon_pkg::VCO_TEST_RESET;
         load_en_r  <= temp_mon_pkg::LOAD_RESET;
      end else begin
         if (wr_vco) begin
            vco_test_r <= wr_data_in[1:0];
         end
         if (wr_load) begin
            load_en_r <= wr_data_in[temp_mon_pkg::LOAD_EN_BIT];
         end
      end
   end

   // config writes land in a stage and commit only after the pending time,
   // so reads during the window show the old settings with the pending bit set
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg_stage_r <= temp_mon_pkg::CONFIG_RESET;
         pending_r   <= 1'b0;
         pend_cnt_r  <= '0;
      end else if (cfg_take) begin
         cfg_stage_r <= wr_data_in;
         pending_r   <= 1'b1;
         pend_cnt_r  <= '0;
      end else if (cfg_commit) begin
         pending_r  <= 1'b0;
         pend_cnt_r <= '0;
      end else if (pending_r) begin
         pend_cnt_r <= pend_cnt_r + PEND_W'(1);
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         interval_r   <= temp_mon_pkg::CONFIG_RESET[2:0];
         bat_check_r  <= temp_mon_pkg::CONFIG_RESET[temp_mon_pkg::CFG_BAT_BIT];
         supply_sel_r <= temp_mon_pkg::CONFIG_RESET[temp_mon_pkg::CFG_PWR_BIT];
         batt_sel_r   <= temp_mon_pkg::CONFIG_RESET[temp_mon_pkg::CFG_BSEL_BIT];
      end else if (cfg_commit) begin
         interval_r   <= cfg_stage_r[2:0];
         bat_check_r  <= cfg_stage_r[temp_mon_pkg::CFG_BAT_BIT];
         supply_sel_r <= cfg_stage_r[temp_mon_pkg::CFG_PWR_BIT];
         batt_sel_r   <= cfg_stage_r[temp_mon_pkg::CFG_BSEL_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interval timer: one-second tick, then a seconds count up to the period

   wire       is_manual     = (interval_r == temp_mon_pkg::INTERVAL_MANUAL);
   wire       is_continuous = (interval_r == temp_mon_pkg::INTERVAL_CONTINUOUS);
   wire       is_periodic   = !is_manual && !is_continuous;
   wire       sec_tick      = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));
   wire [3:0] period_exp    = {1'b0, interval_r} + temp_mon_pkg::INTERVAL_BASE_EXP;
   wire [9:0] period_len    = 10'h001 << period_exp;
   wire [8:0] period_last   = 9'(period_len - 10'h001);
   wire       period_hit    = is_periodic && sec_tick && (sec_cnt_r == period_last);

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tick_cnt_r <= '0;
         sec_cnt_r  <= '0;
      end else if (cfg_commit) begin
         tick_cnt_r <= '0;
         sec_cnt_r  <= '0;
      end else begin
         tick_cnt_r <= sec_tick ? '0 : tick_cnt_r + TICK_W'(1);
         if (period_hit) begin
            sec_cnt_r <= '0;
         end else if (is_periodic && sec_tick) begin
            sec_cnt_r <= sec_cnt_r + SEC_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // measurement scheduling

   // start_r blocks a second start before the sequencer shows busy
   wire can_start   = !m.busy && !start_r;
   wire manual_ok   = is_manual && !low_power;
   wire manual_go   = manual_ok && trigger_r && !manual_run_r && can_start;
   wire auto_go     = can_start && (is_continuous || periodic_req_r);
   wire start_go    = manual_go || auto_go;
   wire manual_done = m.done && manual_run_r;

   // a software write in the completion cycle wins over the hardware clear
   always_comb begin
      trigger_nxt = trigger_r;
      if (wr_trig) begin
         trigger_nxt = wr_data_in[temp_mon_pkg::TRIGGER_BIT];
      end else if (manual_done) begin
         trigger_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         trigger_r      <= temp_mon_pkg::TRIGGER_RESET;
         manual_run_r   <= 1'b0;
         start_r        <= 1'b0;
         batt_taken_r   <= 1'b0;
         periodic_req_r <= 1'b0;
      end else begin
         trigger_r <= trigger_nxt;
         start_r   <= start_go;
         if (manual_go) begin
            manual_run_r <= 1'b1;
         end else if (manual_done) begin
            manual_run_r <= 1'b0;
         end
         if (start_go) begin
            batt_taken_r <= bat_check_r;
         end
         if (period_hit) begin
            periodic_req_r <= 1'b1;
         end else if (auto_go || !is_periodic) begin
            periodic_req_r <= 1'b0;
         end
      end
   end

   assign m.start   = start_r;
   assign m.batt_en = batt_taken_r;

   measure_sequencer u_seq (
      .clk_in               (clk_in),
      .reset_n_in           (reset_n_in),
      .m                    (m),
      .sensor_done_in       (sensor_done_in),
      .sensor_temp_in       (sensor_temp_in),
      .sensor_batt_in       (sensor_batt_in),
      .sensor_run_out       (sensor_run_out),
      .sensor_batt_meas_out (sensor_batt_meas_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // results: both temperature bytes share one capture edge

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         temp_r <= temp_mon_pkg::TEMP_RESET;
         batt_r <= temp_mon_pkg::BATT_RESET;
      end else if (m.done) begin
         temp_r <= m.temp;
         if (m.batt_en) begin
            batt_r <= m.batt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // analog controls; supply follows the register live, even mid-conversion,
   // so a stalled battery-powered run can be rescued by a switch to the rail

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         supply_r <= 1'b0;
         load_r   <= 1'b0;
      end else begin
         supply_r <= supply_sel_r && !low_power;
         load_r   <= load_en_r && normal_pwr;
      end
   end

   assign sensor_supply_digital_out = supply_r;
   assign battery_main_sel_out      = batt_sel_r;
   assign battery_load_en_out       = load_r;
   assign sensor_vco_test_out       = vco_test_r;

   ////////////////////////////////////////////////////////////////////////////////
   // read port: data in the cycle after the strobe only, zero elsewhere

   wire [7:0] cfg_view  = {batt_sel_r, supply_sel_r, 1'b0, bat_check_r, pending_r, interval_r};
   wire [7:0] trig_view = {1'b0, trigger_r, 6'h00};
   wire [7:0] load_view = {4'h0, load_en_r, 3'h0};
   wire [7:0] rd_mux    = hit_vco  ? {6'h00, vco_test_r} :
                          hit_load ? load_view :
                          hit_thi  ? temp_r[10:3] :
                          hit_tlo  ? {temp_r[2:0], 5'h00} :
                          hit_batt ? batt_r :
                          hit_cfg  ? cfg_view :
                          hit_trig ? trig_view : 8'h00;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_data_r <= 8'h00;
      end else begin
         rd_data_r <= rd_in ? rd_mux : 8'h00;
      end
   end

   assign rd_data_out = rd_data_r;

endmodule

// [bench/die_temp_battery_monitor_sva.sv]
// port checker for the die temperature and battery monitor
// assumes binding to the top module; one clock, async active-low reset
`timescale 1ns/1ps
module die_temp_battery_monitor_sva #(
   parameter int WRITE_PENDING_CYCLES = 20,
   parameter int TICK_CYCLES          = 10
) (
   input wire logic                      clk_in,
   input wire logic                      reset_n_in,
   input wire logic [15:0]               addr_in,
   input wire logic [7:0]                wr_data_in,
   input wire logic                      wr_in,
   input wire logic                      rd_in,
   input wire logic [7:0]                rd_data_out,
   input wire temp_mon_pkg::power_mode_t power_mode_in,
   input wire logic                      sensor_done_in,
   input wire logic [10:0]               sensor_temp_in,
   input wire logic [7:0]                sensor_batt_in,
   input wire logic                      sensor_run_out,
   input wire logic                      sensor_batt_meas_out,
   input wire logic                      sensor_supply_digital_out,
   input wire logic                      battery_main_sel_out,
   input wire logic                      battery_load_en_out,
   input wire logic [1:0]                sensor_vco_test_out
);
   int         pend_cnt_r;
   logic       load_r;
   logic [1:0] vco_r;
   wire        cfg_wr  = wr_in && addr_in == temp_mon_pkg::ADDR_CONFIG;
   wire        pend    = pend_cnt_r != 0;
   wire        normal  = power_mode_in == temp_mon_pkg::normal_power_mode;
   wire        low_pwr = power_mode_in == temp_mon_pkg::display_only_mode ||
                         power_mode_in == temp_mon_pkg::deep_sleep_mode;

   ////////////////////////////////////////////////////////////////////////////////
   // shadow of the write-pending window and the plain RW bits
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pend_cnt_r <= 0;
         load_r     <= 1'b0;
         vco_r      <= 2'h0;
      end else begin
         if (cfg_wr && !pend) begin
            pend_cnt_r <= WRITE_PENDING_CYCLES;
         end else if (pend) begin
            pend_cnt_r <= pend_cnt_r - 1;
         end
         if (wr_in && addr_in == temp_mon_pkg::ADDR_LOAD) begin
            load_r <= wr_data_in[temp_mon_pkg::LOAD_EN_BIT];
         end
         if (wr_in && addr_in == temp_mon_pkg::ADDR_VCO_TEST) begin
            vco_r <= wr_data_in[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   pend_flag_a: assert property (
      rd_in && addr_in == temp_mon_pkg::ADDR_CONFIG |=> rd_data_out[3] == $past(pend))
      else $error("pending flag off its window");
   lo_pad_a: assert property (
      rd_in && addr_in == temp_mon_pkg::ADDR_TEMP_LO |=> rd_data_out[4:0] == 5'h00)
      else $error("low result byte padding not zero");
   // two stable cycles so either one or two register stages pass
   load_follow_a: assert property (
      ($stable(load_r) && $stable(normal))[*2] |-> battery_load_en_out == (load_r && normal))
      else $error("load output does not follow enable and mode");
   load_mode_a: assert property (
      (!normal)[*2] |-> !battery_load_en_out)
      else $error("load applied outside normal mode");
   vco_copy_a: assert property (
      $stable(vco_r)[*2] |-> sensor_vco_test_out == vco_r)
      else $error("test field output differs from register");
   supply_mode_a: assert property (
      low_pwr[*2] |-> !sensor_supply_digital_out)
      else $error("digital rail used in a low power mode");
   run_fall_a: assert property (
      sensor_run_out && sensor_done_in |-> ##[1:5] !sensor_run_out)
      else $error("run request outlived sensor done");
   run_hold_a: assert property (
      (sensor_run_out && !sensor_done_in)[*3] |=> sensor_run_out)
      else $error("run request dropped before done");
   batt_with_run_a: assert property (
      $rose(sensor_batt_meas_out) |-> $rose(sensor_run_out))
      else $error("battery measure raised outside a run start");

   trig_c: cover property (wr_in && addr_in == temp_mon_pkg::ADDR_TRIGGER ##[1:4]
                           $rose(sensor_run_out));
   pend_c: cover property (cfg_wr && pend);
   done_c: cover property ($fell(sensor_run_out));
   load_c: cover property (battery_load_en_out);
endmodule

bind die_temp_battery_monitor die_temp_battery_monitor_sva #(
   .WRITE_PENDING_CYCLES(WRITE_PENDING_CYCLES), .TICK_CYCLES(TICK_CYCLES)) i_sva (
   .clk_in, .reset_n_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out, .power_mode_in,
   .sensor_done_in, .sensor_temp_in, .sensor_batt_in, .sensor_run_out, .sensor_batt_meas_out,
   .sensor_supply_digital_out, .battery_main_sel_out, .battery_load_en_out, .sensor_vco_test_out);

// [bench/die_temp_battery_monitor_test.sv]
// self-checking bench for the die temperature and battery monitor
// assumes the bound checker; the bench plays both software and the sensor
`timescale 1ns/1ps
module die_temp_battery_monitor_test;
   localparam int          WPC   = 20;
   localparam int          TCK   = 10;
   localparam logic [15:0] A_CFG = temp_mon_pkg::ADDR_CONFIG;
   localparam logic [15:0] A_TRG = temp_mon_pkg::ADDR_TRIGGER;
   localparam logic [15:0] A_HI  = temp_mon_pkg::ADDR_TEMP_HI;
   localparam logic [15:0] A_LO  = temp_mon_pkg::ADDR_TEMP_LO;
   localparam logic [15:0] A_BAT = temp_mon_pkg::ADDR_BATT;
   logic                      clk_in         = 1'b0;
   logic                      reset_n_in     = 1'b0;
   logic [15:0]               addr_in        = 16'h0000;
   logic [7:0]                wr_data_in     = 8'h00;
   logic                      wr_in          = 1'b0;
   logic                      rd_in          = 1'b0;
   temp_mon_pkg::power_mode_t power_mode_in  = temp_mon_pkg::normal_power_mode;
   logic                      sensor_done_in = 1'b0;
   logic [10:0]               sensor_temp_in = 11'h000;
   logic [7:0]                sensor_batt_in = 8'h00;
   logic [7:0]                rd_data_out;
   logic                      sensor_run_out, sensor_batt_meas_out, sensor_supply_digital_out;
   logic                      battery_main_sel_out, battery_load_en_out, bm;
   logic [1:0]                sensor_vco_test_out;
   logic [10:0]               t;
   int                        n_errors = 0;
   int                        samples_checked = 0;
   int                        k;

   die_temp_battery_monitor #(.WRITE_PENDING_CYCLES(WPC), .TICK_CYCLES(TCK)) i_dut (
      .clk_in, .reset_n_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out, .power_mode_in,
      .sensor_done_in, .sensor_temp_in, .sensor_batt_in, .sensor_run_out, .sensor_batt_meas_out,
      .sensor_supply_digital_out, .battery_main_sel_out, .battery_load_en_out,
      .sensor_vco_test_out);

   always #5 clk_in = ~clk_in;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk_in);
      addr_in    <= a;
      wr_data_in <= v;
      wr_in      <= 1'b1;
      @(posedge clk_in);
      wr_in      <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1;
      chk(rd_data_out, exp);
   endtask

   // bounded wait on run, k counts the edges
   task automatic wait_run(input logic lvl, input int lim);
      k = 0;
      do begin
         @(posedge clk_in);
         #1;
         k++;
      end while (sensor_run_out !== lvl && k < lim);
      chk({7'h00, sensor_run_out}, {7'h00, lvl});
   endtask

   // sensor side: answer one run, then show inverted data
   task automatic sense(input logic [10:0] tv, input logic [7:0] bv);
      if (sensor_run_out !== 1'b1) wait_run(1'b1, 2000);
      bm = sensor_batt_meas_out;
      cyc(3);
      sensor_temp_in <= tv;
      sensor_batt_in <= bv;
      @(posedge clk_in);
      sensor_done_in <= 1'b1;
      wait_run(1'b0, 20);
      cyc(2);
      sensor_done_in <= 1'b0;
      sensor_temp_in <= ~tv;
      sensor_batt_in <= ~bv;
      cyc(4);
   endtask

   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_in);
      reset_n_in <= 1'b1;
      rd(temp_mon_pkg::ADDR_VCO_TEST, 8'h00);
      rd(temp_mon_pkg::ADDR_LOAD, 8'h00);
      rd(A_CFG, 8'h00);
      rd(A_TRG, 8'h00);
      rd(16'h2886, 8'h00);
      chk({1'b0, sensor_vco_test_out, sensor_run_out, sensor_batt_meas_out,
           sensor_supply_digital_out, battery_main_sel_out, battery_load_en_out}, 8'h00);
      wr(A_CFG, 8'hD0);
      rd(A_CFG, 8'h08);
      wr(A_CFG, 8'h07);
      cyc(WPC);
      rd(A_CFG, 8'hD0);
      chk({6'h00, sensor_supply_digital_out, battery_main_sel_out}, 8'h03);
      $display("test config write done");
      // boundary codes, normal then brownout
      for (int i = 0; i < 2; i++) begin
         t = (i == 0) ? 11'h400 : 11'h3FF;
         power_mode_in <= (i == 0) ? temp_mon_pkg::normal_power_mode
                                   : temp_mon_pkg::brownout_power_mode;
         wr(A_TRG, 8'h40);
         rd(A_TRG, 8'h40);
         sense(t, 8'hA5 + 8'(i));
         chk({7'h00, bm}, 8'h01);
         rd(A_TRG, 8'h00);
         rd(A_HI, t[10:3]);
         rd(A_LO, {t[2:0], 5'h00});
         rd(A_BAT, 8'hA5 + 8'(i));
      end
      $display("test manual trigger done");
      power_mode_in <= temp_mon_pkg::deep_sleep_mode;
      wr(A_TRG, 8'h40);
      cyc(10);
      chk({7'h00, sensor_run_out}, 8'h00);
      chk({7'h00, sensor_supply_digital_out}, 8'h00);
      wr(A_TRG, 8'h00);
      rd(A_TRG, 8'h00);
      $display("test sleep trigger done");
      power_mode_in <= temp_mon_pkg::display_only_mode;
      for (int i = 1; i <= 2; i++) begin
         wr(A_CFG, 8'(i));
         wait_run(1'b1, 2000);
         chk({7'h00, k >= WPC + (8 << i) * TCK - 1 && k <= WPC + (8 << i) * TCK + 8}, 8'h01);
         sense(11'h155, 8'h3C);
         chk({7'h00, bm}, 8'h00);
         rd(A_HI, 8'h2A);
         rd(A_BAT, 8'hA6);
      end
      wr(A_CFG, 8'h00);
      cyc(WPC + 2);
      power_mode_in <= temp_mon_pkg::normal_power_mode;
      $display("test periodic done");
      wr(temp_mon_pkg::ADDR_LOAD, 8'h08);
      cyc(3);
      chk({7'h00, battery_load_en_out}, 8'h01);
      rd(temp_mon_pkg::ADDR_LOAD, 8'h08);
      power_mode_in <= temp_mon_pkg::brownout_power_mode;
      cyc(3);
      chk({7'h00, battery_load_en_out}, 8'h00);
      wr(temp_mon_pkg::ADDR_LOAD, 8'h00);
      wr(temp_mon_pkg::ADDR_VCO_TEST, 8'h03);
      cyc(3);
      chk({6'h00, sensor_vco_test_out}, 8'h03);
      rd(temp_mon_pkg::ADDR_VCO_TEST, 8'h03);
      wr(temp_mon_pkg::ADDR_VCO_TEST, 8'h00);
      power_mode_in <= temp_mon_pkg::normal_power_mode;
      $display("test load and test field done");
      wr(A_CFG, 8'h17);
      sense(11'h0F0, 8'h11);
      rd(A_HI, 8'h1E);
      sense(11'h7F8, 8'h22);
      rd(A_HI, 8'hFF);
      wr(A_CFG, 8'h00);
      cyc(WPC + 2);
      sense(11'h001, 8'h01);
      cyc(20);
      chk({7'h00, sensor_run_out}, 8'h00);
      $display("test continuous done");
      stop_test();
   end

   initial begin
      repeat (6000) @(posedge clk_in);
      n_errors++;
      stop_test();
   end
endmodule
